// >>> src/psc_pkg.sv
`default_nettype none
package psc_pkg;
  // Number of general-purpose pins handled by the block
  localparam int          NPIN        = 16;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [3:0]  A_STBY      = 4'h0;  // Standby control register
  localparam logic [3:0]  A_ANALOG    = 4'h4;  // Analogue-capable pin mask
  localparam logic [3:0]  A_STATUS    = 4'h8;  // Phase and pad view
  localparam logic [3:0]  A_OSC       = 4'hc;  // Oscillator use
  // Field positions
  localparam int          B_SLVL      = 0;     // Standby level bit
  localparam int          B_MAINOSC   = 0;
  localparam int          B_SUBOSC    = 1;
  // Reset values
  localparam logic [15:0] ANALOG_RST  = 16'h00ff;
  localparam logic [1:0]  OSC_RST     = 2'h1;
  localparam logic [31:0] UNMAPPED_RD = 32'h00000000;
  // Pin phases
  typedef enum logic [2:0] {
    PSC_INIT_HI  = 3'b000,
    PSC_RUN      = 3'b001,
    PSC_SLEEP    = 3'b010,
    PSC_STANDBY  = 3'b011
  } psc_phase_t;
endpackage : psc_pkg
`default_nettype wire

// >>> src/psc_pin_cell.sv
`default_nettype none
// One pad's drive and input gating for the current phase
module psc_pin_cell (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire psc_pkg::psc_phase_t phase,
  input  wire logic            slvl,
  input  wire logic            analog,
  input  wire logic            eint_sel,
  input  wire logic            eint_en,
  input  wire logic            dma_keep,
  input  wire logic            periph_sel,
  input  wire logic            periph_run,
  input  wire logic            periph_out,
  input  wire logic            periph_oe,
  input  wire logic            port_out,
  input  wire logic            port_oe,
  input  wire logic            pad_sync,
  output logic                 pad_o,
  output logic                 pad_oe,
  output logic                 int_in
);
  logic hold_val_r;
  logic hold_oe_r;
  logic norm_val;
  logic norm_oe;
  logic held;
  logic floated;
  logic in_ok;

  // Normal drive is peripheral or port data
  assign norm_val = periph_sel ? periph_out : port_out;
  assign norm_oe  = periph_sel ? periph_oe  : port_oe;

  // Capture last state while running, frozen once a low-power phase starts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_val_r <= 1'b0;
      hold_oe_r  <= 1'b0;
    end else if (phase == psc_pkg::PSC_RUN) begin
      hold_val_r <= norm_val;
      hold_oe_r  <= norm_oe;
    end
  end

  // Phase decode for this pad
  always_comb begin
    held    = 1'b0;
    floated = 1'b0;
    in_ok   = 1'b1;
    case (phase)
      psc_pkg::PSC_INIT_HI: begin
        floated = 1'b1;
        in_ok   = !analog;
      end
      psc_pkg::PSC_RUN: begin
      end
      psc_pkg::PSC_SLEEP: begin
        // Bus group turns input instead of holding its last drive
        if (dma_keep) begin
          floated = 1'b1;
        end else begin
          held = 1'b1;
        end
      end
      default: begin
        if (slvl || analog) begin
          floated = 1'b1;
          in_ok   = eint_sel && eint_en;
        end else begin
          held = 1'b1;
        end
      end
    endcase
  end

  // Output: a running peripheral keeps driving even when held
  always_comb begin
    if (!nrst || floated) begin
      pad_oe = 1'b0;
      pad_o  = 1'b0;
    end else if (held && !(periph_sel && periph_run)) begin
      pad_oe = hold_oe_r;
      pad_o  = hold_val_r;
    end else begin
      pad_oe = norm_oe;
      pad_o  = norm_val;
    end
  end

  // Gated input reads zero when cut off from the pad
  assign int_in = (nrst && in_ok) ? pad_sync : 1'b0;
endmodule : psc_pin_cell
`default_nettype wire

// >>> src/psc_top.sv
// Chosen here: the Avalon-MM register port and the register addresses.
`default_nettype none
module psc_top (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic [3:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        sleep_req,
  input  wire logic                        standby_req,
  input  wire logic [psc_pkg::NPIN-1:0]    eint_sel,
  input  wire logic [psc_pkg::NPIN-1:0]    eint_en,
  input  wire logic [psc_pkg::NPIN-1:0]    dma_group,
  input  wire logic                        dma_keep_in,
  input  wire logic [psc_pkg::NPIN-1:0]    periph_sel,
  input  wire logic [psc_pkg::NPIN-1:0]    periph_run,
  input  wire logic [psc_pkg::NPIN-1:0]    periph_out,
  input  wire logic [psc_pkg::NPIN-1:0]    periph_oe,
  input  wire logic [psc_pkg::NPIN-1:0]    port_out,
  input  wire logic [psc_pkg::NPIN-1:0]    port_oe,
  input  wire logic [psc_pkg::NPIN-1:0]    pad_i,
  output logic [psc_pkg::NPIN-1:0]         pad_o,
  output logic [psc_pkg::NPIN-1:0]         pad_oe,
  output logic [psc_pkg::NPIN-1:0]         int_in,
  output logic                             main_osc_in_en,
  output logic                             main_osc_out_o,
  output logic                             main_osc_out_oe,
  output logic                             sub_osc_in_en,
  output logic                             sub_osc_out_o,
  output logic                             sub_osc_out_oe
);
  localparam int N = psc_pkg::NPIN;

  logic                 standby_pin_level_bit_r;
  logic [N-1:0]         analog_mask_r;
  logic [1:0]           osc_use_r;
  psc_pkg::psc_phase_t  phase_r;
  psc_pkg::psc_phase_t  phase_nxt;
  logic [N-1:0]         pad_s1_r;
  logic [N-1:0]         pad_s2_r;
  logic                 rd_pend_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rd_mux;
  logic                 in_standby;

  // Pads come from outside the clock domain: two flops before use
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      pad_s1_r <= pad_i;
      pad_s2_r <= pad_s1_r;
    end
  end

  // Phase sequencing; standby has priority over sleep
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      psc_pkg::PSC_INIT_HI: begin
        phase_nxt = psc_pkg::PSC_RUN;
      end
      psc_pkg::PSC_RUN: begin
        if (standby_req) begin
          phase_nxt = psc_pkg::PSC_STANDBY;
        end else if (sleep_req) begin
          phase_nxt = psc_pkg::PSC_SLEEP;
        end
      end
      psc_pkg::PSC_SLEEP: begin
        if (!sleep_req) begin
          phase_nxt = psc_pkg::PSC_RUN;
        end
      end
      default: begin
        if (!standby_req) begin
          phase_nxt = psc_pkg::PSC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= psc_pkg::PSC_INIT_HI;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Software registers; each write lands in one cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      standby_pin_level_bit_r <= 1'b0;
      analog_mask_r           <= psc_pkg::ANALOG_RST;
      osc_use_r               <= psc_pkg::OSC_RST;
    end else if (avs_write) begin
      if (avs_address == psc_pkg::A_STBY && avs_byteenable[0]) begin
        standby_pin_level_bit_r <= avs_writedata[psc_pkg::B_SLVL];
      end else if (avs_address == psc_pkg::A_ANALOG) begin
        if (avs_byteenable[0]) begin
          analog_mask_r[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          analog_mask_r[15:8] <= avs_writedata[15:8];
        end
      end else if (avs_address == psc_pkg::A_OSC && avs_byteenable[0]) begin
        osc_use_r <= avs_writedata[1:0];
      end
    end
  end

  // Read decode; unmapped addresses return zero
  always_comb begin
    rd_mux = psc_pkg::UNMAPPED_RD;
    if (avs_address == psc_pkg::A_STBY) begin
      rd_mux[psc_pkg::B_SLVL] = standby_pin_level_bit_r;
    end else if (avs_address == psc_pkg::A_ANALOG) begin
      rd_mux[15:0] = analog_mask_r;
    end else if (avs_address == psc_pkg::A_STATUS) begin
      rd_mux[15:0]  = int_in;
      rd_mux[18:16] = phase_r;
    end else if (avs_address == psc_pkg::A_OSC) begin
      rd_mux[1:0] = osc_use_r;
    end
  end

  // Reads take one wait cycle so read data comes from a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_pend_r <= 1'b0;
      rdata_r   <= '0;
    end else begin
      rd_pend_r <= avs_read && !rd_pend_r;
      if (avs_read && !rd_pend_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = avs_read && !rd_pend_r;

  // One cell per pin
  generate
    for (genvar i = 0; i < N; i++) begin : g_pin
      psc_pin_cell u_cell (
        .clk        (clk),
        .nrst       (nrst),
        .phase      (phase_r),
        .slvl       (standby_pin_level_bit_r),
        .analog     (analog_mask_r[i]),
        .eint_sel   (eint_sel[i]),
        .eint_en    (eint_en[i]),
        .dma_keep   (dma_group[i] && dma_keep_in),
        .periph_sel (periph_sel[i]),
        .periph_run (periph_run[i]),
        .periph_out (periph_out[i]),
        .periph_oe  (periph_oe[i]),
        .port_out   (port_out[i]),
        .port_oe    (port_oe[i]),
        .pad_sync   (pad_s2_r[i]),
        .pad_o      (pad_o[i]),
        .pad_oe     (pad_oe[i]),
        .int_in     (int_in[i])
      );
    end
  endgenerate

  // Oscillator pins: in standby, unused oscillators float in, drive high out
  assign in_standby      = (phase_r == psc_pkg::PSC_STANDBY);
  assign main_osc_in_en  = !in_standby || osc_use_r[psc_pkg::B_MAINOSC];
  assign main_osc_out_o  = 1'b1;
  assign main_osc_out_oe = in_standby && !osc_use_r[psc_pkg::B_MAINOSC];
  assign sub_osc_in_en   = in_standby && osc_use_r[psc_pkg::B_SUBOSC];
  assign sub_osc_out_o   = 1'b1;
  assign sub_osc_out_oe  = in_standby && !osc_use_r[psc_pkg::B_SUBOSC];

  // Bus group pins that go input in sleep
  logic [N-1:0] dma_live;
  assign dma_live = dma_group & {N{dma_keep_in}};

  // Checks
  a_init_float: assert property (@(posedge clk)
    !nrst |-> pad_oe == '0) else $error("pad driven in init");
  a_after_init: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_INIT_HI |-> pad_oe == '0 &&
    (int_in & analog_mask_r) == '0) else $error("init-high gating");
  a_slvl_write: assert property (@(posedge clk) disable iff (!nrst)
    avs_write && avs_address == psc_pkg::A_STBY && avs_byteenable[0]
    |=> standby_pin_level_bit_r == $past(avs_writedata[0]))
    else $error("level bit not stored");
  a_stby1_float: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && standby_pin_level_bit_r |-> pad_oe == '0)
    else $error("standby pad driven");
  a_force_zero: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && standby_pin_level_bit_r |->
    (int_in & ~(eint_sel & eint_en)) == '0)
    else $error("forced input nonzero");
  a_eint_live: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && standby_pin_level_bit_r |->
    int_in == (pad_s2_r & eint_sel & eint_en))
    else $error("interrupt input dropped");
  a_stby0_float: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && !standby_pin_level_bit_r |->
    (pad_oe & analog_mask_r) == '0) else $error("analog driven");
  a_wake_run: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP && !sleep_req
    |=> phase_r == psc_pkg::PSC_RUN) else $error("no wake");
  a_run_norm: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_RUN |->
    pad_oe == ((periph_sel & periph_oe) | (~periph_sel & port_oe)))
    else $error("run drive wrong");
  a_osc_high: assert property (@(posedge clk) disable iff (!nrst)
    !in_standby |-> !main_osc_out_oe && !sub_osc_out_oe)
    else $error("osc out outside standby");

  // Sleep: bus group released when its input is kept
  a_sleep_dma: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP |-> (pad_oe & dma_live) == '0)
    else $error("bus group driven in sleep");

  // Sleep keeps every input live
  a_sleep_in: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP |-> int_in == pad_s2_r)
    else $error("sleep input gated");

  // First sleep cycle repeats the last run drive enable
  a_held_oe: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP && $past(phase_r) == psc_pkg::PSC_RUN
    |-> ((pad_oe ^ $past(pad_oe)) & ~(periph_sel & periph_run)
    & ~dma_live) == '0) else $error("held enable moved");

  // First sleep cycle repeats the last run data
  a_held_val: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP && $past(phase_r) == psc_pkg::PSC_RUN
    |-> ((pad_o ^ $past(pad_o)) & ~(periph_sel & periph_run)
    & ~dma_live) == '0) else $error("held value moved");

  // Running: inputs pass the synchroniser untouched
  a_run_in: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_RUN |-> int_in == pad_s2_r)
    else $error("run input gated");

  // Just after init: digital pins already read their pads
  a_init_dig: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_INIT_HI |->
    (int_in & ~analog_mask_r) == (pad_s2_r & ~analog_mask_r))
    else $error("digital input off after init");

  // Init pin low: nothing reaches the core
  a_reset_in: assert property (@(posedge clk)
    !nrst |-> int_in == '0) else $error("input live in init");

  // The post-init phase lasts one cycle
  a_init_step: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_INIT_HI |=> phase_r == psc_pkg::PSC_RUN)
    else $error("stuck after init");

  // Standby request wins over sleep
  a_stby_enter: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_RUN && standby_req |=> in_standby)
    else $error("standby not entered");

  // Sleep request alone enters sleep
  a_sleep_enter: assert property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_RUN && sleep_req && !standby_req
    |=> phase_r == psc_pkg::PSC_SLEEP) else $error("sleep not entered");

  // Standby ends one cycle after its request drops
  a_stby_wake: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && !standby_req |=> phase_r == psc_pkg::PSC_RUN)
    else $error("no wake from standby");

  // Level zero: analogue inputs forced unless interrupt
  a_stby0_force: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && !standby_pin_level_bit_r |->
    (int_in & analog_mask_r & ~(eint_sel & eint_en)) == '0)
    else $error("analog input not forced");

  // Level zero: enabled interrupt pins still see the pad
  a_stby0_eint: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && !standby_pin_level_bit_r |->
    (int_in & analog_mask_r) ==
    (pad_s2_r & analog_mask_r & eint_sel & eint_en))
    else $error("interrupt input lost");

  // Level zero: digital pins keep their run drive
  a_stby0_hold: assert property (@(posedge clk) disable iff (!nrst)
    in_standby && !standby_pin_level_bit_r &&
    $past(phase_r) == psc_pkg::PSC_RUN |->
    ((pad_oe ^ $past(pad_oe)) & ~analog_mask_r
    & ~(periph_sel & periph_run)) == '0) else $error("digital not held");

  // Standby: main oscillator input follows its use
  a_osc_main_in: assert property (@(posedge clk) disable iff (!nrst)
    in_standby |-> main_osc_in_en == osc_use_r[psc_pkg::B_MAINOSC])
    else $error("main osc input wrong");

  // Standby: sub oscillator input follows its use
  a_osc_sub_in: assert property (@(posedge clk) disable iff (!nrst)
    in_standby |-> sub_osc_in_en == osc_use_r[psc_pkg::B_SUBOSC])
    else $error("sub osc input wrong");

  // Standby: an unused main oscillator drives high
  a_osc_drive: assert property (@(posedge clk) disable iff (!nrst)
    in_standby |-> main_osc_out_oe == !osc_use_r[psc_pkg::B_MAINOSC])
    else $error("main osc drive wrong");

  // Writes never wait
  a_wr_nowait: assert property (@(posedge clk) disable iff (!nrst)
    avs_write |-> !avs_waitrequest) else $error("write stalled");

  // Reads wait exactly one cycle
  a_rd_one: assert property (@(posedge clk) disable iff (!nrst)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait too long");

  // Level bit read back as stored
  a_rd_slvl: assert property (@(posedge clk) disable iff (!nrst)
    avs_read && !avs_waitrequest && avs_address == psc_pkg::A_STBY
    |-> avs_readdata[psc_pkg::B_SLVL] == standby_pin_level_bit_r)
    else $error("level bit readback");

  c_sleep: cover property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP ##1 phase_r == psc_pkg::PSC_RUN);
  c_stby1: cover property (@(posedge clk) disable iff (!nrst)
    in_standby && standby_pin_level_bit_r);
  c_stby0: cover property (@(posedge clk) disable iff (!nrst)
    in_standby && !standby_pin_level_bit_r);
  c_dma_sleep: cover property (@(posedge clk) disable iff (!nrst)
    phase_r == psc_pkg::PSC_SLEEP && dma_keep_in);
  c_rd_done: cover property (@(posedge clk) disable iff (!nrst)
    avs_read && !avs_waitrequest);
endmodule : psc_top
`default_nettype wire

// >>> sim/psc_board.sv
`default_nettype none
// Board side of the pads: each wire resolved from chip and board drivers
module psc_board (
  input  wire logic [psc_pkg::NPIN-1:0] pad_o,
  input  wire logic [psc_pkg::NPIN-1:0] pad_oe,
  input  wire logic [psc_pkg::NPIN-1:0] ext,
  output logic      [psc_pkg::NPIN-1:0] pad_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floated pin shows the board level, never a stale chip value
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext);
endmodule : psc_board
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] AM = psc_pkg::ANALOG_RST;
  logic        clk, nrst, rd, wr, slp, stb, dkeep, wt, lvl;
  logic        moi, moo, mooe, soi, soo, sooe;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, q, rnd;
  logic [15:0] esel, een, dgrp, psel, prun, pout, poe, qout, qoe, ext;
  logic [15:0] pi, po, oe, ii, ho, hoe, eo, eoe, pad;
  logic [1:0]  osc;
  int          errors, check_count;

  psc_top u_dut (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wt), .sleep_req(slp),
    .standby_req(stb), .eint_sel(esel), .eint_en(een), .dma_group(dgrp),
    .dma_keep_in(dkeep), .periph_sel(psel), .periph_run(prun),
    .periph_out(pout), .periph_oe(poe), .port_out(qout), .port_oe(qoe),
    .pad_i(pi), .pad_o(po), .pad_oe(oe), .int_in(ii),
    .main_osc_in_en(moi), .main_osc_out_o(moo), .main_osc_out_oe(mooe),
    .sub_osc_in_en(soi), .sub_osc_out_o(soo), .sub_osc_out_oe(sooe));
  psc_board u_brd (.pad_o(po), .pad_oe(oe), .ext(ext), .pad_i(pi));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] mux(input logic [15:0] s, a, b);
    return (s & a) | (~s & b);
  endfunction : mux

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Held until waitrequest is seen low; bounded so a stuck slave ends the run
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a; wr <= w; rd <= !w; wd <= d;
    n = 0;
    @(posedge clk);
    while (wt !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
    if (n >= 20) begin
      errors++;
      wrap_up();
    end
  endtask : bus

  // Port side reshuffled; peripheral and interrupt setup too when asked
  task automatic scramble(input logic all);
    rnd = lfsr(rnd); qout <= rnd[15:0]; qoe <= rnd[31:16] ^ rnd[15:0];
    rnd = lfsr(rnd); pout <= rnd[15:0]; poe <= rnd[31:16];
    if (all) begin
      rnd = lfsr(rnd); psel <= rnd[15:0]; prun <= rnd[31:16] ^ rnd[15:0];
      rnd = lfsr(rnd); esel <= rnd[15:0]; een <= rnd[31:16];
      rnd = lfsr(rnd); ext <= rnd[15:0]; dgrp <= rnd[31:16]; dkeep <= rnd[3];
      osc = rnd[5:4];
    end
  endtask : scramble

  // Three edges cover the phase step and the two-flop pad sync
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic chk_run;
    eo = mux(psel, pout, qout);
    eoe = mux(psel, poe, qoe);
    pad = mux(eoe, eo, ext);
    `CHK("run_oe", eoe, oe)
    `CHK("run_o", eo & eoe, po & eoe)
    `CHK("run_in", pad & ~AM, ii & ~AM)
  endtask : chk_run

  initial begin
    nrst = 1'b0; rd = 1'b0; wr = 1'b0; adr = 4'h0; wd = 32'h0; slp = 1'b0;
    stb = 1'b0; dkeep = 1'b0; esel = 16'h0; een = 16'h0; dgrp = 16'h0;
    psel = 16'h0; prun = 16'h0; pout = 16'hffff; poe = 16'hffff;
    qout = 16'hffff; qoe = 16'hffff; ext = 16'h5a5a; rnd = 32'hd512;
    errors = 0; check_count = 0; osc = 2'h0;
    repeat (16) @(posedge clk);
    #1 `CHK("oe_init_low", 16'h0, oe)
    @(posedge clk) nrst <= 1'b1;
    #1 `CHK("oe_init_high", 16'h0, oe)
    `CHK("in_init_high", 16'h0, ii & AM)
    bus(1'b0, psc_pkg::A_ANALOG, 32'h0);
    `CHK("analog_rst", AM, q[15:0])
    bus(1'b0, psc_pkg::A_OSC, 32'h0);
    `CHK("osc_rst", psc_pkg::OSC_RST, q[1:0])
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", psc_pkg::UNMAPPED_RD, q)
    bus(1'b0, psc_pkg::A_STATUS, 32'h0);
    `CHK("phase", psc_pkg::PSC_RUN, q[18:16])
    // Sleep, standby at level 0 and standby at level 1, twice each
    for (int k = 0; k < 6; k++) begin
      lvl = (k % 3 == 2);
      scramble(1'b1);
      bus(1'b1, psc_pkg::A_STBY, {31'h0, lvl});
      bus(1'b0, psc_pkg::A_STBY, 32'h0);
      `CHK("slvl", lvl, q[psc_pkg::B_SLVL])
      bus(1'b1, psc_pkg::A_OSC, {30'h0, osc});
      settle();
      chk_run();
      ho = eo;
      hoe = eoe;
      @(posedge clk) if (k % 3 == 0) slp <= 1'b1; else stb <= 1'b1;
      settle();
      scramble(1'b0);
      settle();
      eo = mux(psel & prun, pout, ho);
      eoe = mux(psel & prun, poe, hoe);
      if (k % 3 == 2) eoe = 16'h0;
      if (k % 3 == 1) eoe = eoe & ~AM;
      if (k % 3 == 0 && dkeep) eoe = eoe & ~dgrp;
      pad = mux(eoe, eo, ext);
      `CHK("mode_oe", eoe, oe)
      `CHK("mode_o", eo & eoe, po & eoe)
      if (k % 3 == 2) `CHK("in_lvl1", pad & esel & een, ii)
      if (k % 3 == 1) `CHK("in_lvl0", pad & esel & een & AM, ii & AM)
      if (k % 3 == 0 && dkeep) `CHK("in_dma", pad & dgrp, ii & dgrp)
      if (k % 3 != 0) begin
        `CHK("mosc_in", osc[0], moi)
        `CHK("mosc_oe", ~osc[0], mooe)
        `CHK("sosc_in", osc[1], soi)
        `CHK("sosc_oe", ~osc[1], sooe)
        `CHK("osc_hi", 2'h3, {moo | ~mooe, soo | ~sooe})
      end
      @(posedge clk) begin
        slp <= 1'b0;
        stb <= 1'b0;
      end
      settle();
      chk_run();
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
